// ===== rtl/tcdma_top.sv
// tcdma_top: two dma channels, apb registers, bus master port.
// assumes the system bus grants the controller ahead of the core and
// answers each read or write with mem_ack_i high for one cycle.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps

// Operation
// - channel zero wins simultaneous requests
// - each side fixed or forward over 1M
// - register window 0020-003F never transferred
// - 8/16-bit units, 16-bit counter
// - pin requests, falling or both edges
// - peripheral causes and software trigger selectable
// - never both pointers forward at once
// - single mode underflow clears enable
// - interrupt pulse on every underflow
// - one unit per request while enabled
// - enable zero stops new transfers
// - enabling loads pointer and counter
// - fixed pointers writable only when disabled
// - enabled read returns forward pointer
// - transfers ignore core interrupt state
// - controller owns bus before core
// - unit bit clear 16, set 8
// - software request bit reads zero
// - pending bit cleared only by zero; the engine here also clears it when the read of a unit is acknowledged
module tcdma_top
  import tcdma_pkg::*;
#(
  parameter int NCAUSE = 16
)(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ext_irq_pin_zero_i,
  input wire logic ext_irq_pin_one_i,
  input wire logic [NCAUSE-1:0] periph_req_i,
  output tcdma_bus_req_t mem_req_o,
  output logic bus_own_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  output logic [1:0] dma_irq_o
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RD = 5'b00010,
    ST_WR = 5'b00100,
    ST_UPD = 5'b01000,
    ST_SKIP = 5'b10000
  } tcdma_state_t;

  tcdma_state_t state_r;
  tcdma_ctrl_t [1:0] ctrl_r;
  logic [1:0][3:0] cause_r;
  logic [1:0] expand_r;
  logic [1:0][19:0] src_r;
  logic [1:0][19:0] dst_r;
  logic [1:0][19:0] fwd_r;
  logic [1:0][15:0] reload_r;
  logic [1:0][15:0] count_r;
  logic [1:0] pin_d_r;
  logic [1:0] req_ev;
  logic [1:0] start_en;
  logic ch_r;
  logic [15:0] data_r;
  logic [19:0] rd_addr;
  logic [19:0] wr_addr;
  logic [1:0] sw_req;
  logic [1:0] wr_ctrl;
  logic [1:0] wr_cause;
  logic [1:0] wr_src;
  logic [1:0] wr_dst;
  logic [1:0] wr_reload;
  logic [1:0] underflow;
  logic apb_wr;
  logic ch_sel;
  logic [7:0] ofs;
  logic [31:0] rd_mux;

  // ==========================================================
  // apb decode
  // ==========================================================
  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign ch_sel = paddr_i[5];
  assign ofs = paddr_i & 8'h1F;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && (paddr_i[7:6] != 2'b00
                   || ofs > TCDMA_OFS_STATUS || paddr_i[1:0] != 2'b00);
      prdata_o <= (psel_i && !penable_i && !pwrite_i) ? rd_mux
                  : prdata_o;
    end
  end

  // ==========================================================
  // per channel registers and request detection
  // ==========================================================
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ch
      logic pin_now;
      logic pin_ev;
      logic cause_ev;
      logic hit;
      assign hit = apb_wr && paddr_i[7:6] == 2'b00 && ch_sel == gi[0];
      assign wr_ctrl[gi] = hit && ofs == TCDMA_OFS_CTRL;
      assign wr_cause[gi] = hit && ofs == TCDMA_OFS_CAUSE;
      assign wr_src[gi] = hit && ofs == TCDMA_OFS_SRC
        && (!ctrl_r[gi].enable || ctrl_r[gi].src_dir);
      assign wr_dst[gi] = hit && ofs == TCDMA_OFS_DST
        && (!ctrl_r[gi].enable || ctrl_r[gi].dst_dir);
      assign wr_reload[gi] = hit && ofs == TCDMA_OFS_RELOAD;
      assign sw_req[gi] = wr_cause[gi] && pwdata_i[TCDMA_B_SWREQ]
        && pwdata_i[3:0] == TCDMA_CAUSE_SW;
      assign pin_now = (gi == 0) ? ext_irq_pin_zero_i : ext_irq_pin_one_i;
      // falling edge always, rising too in two-edge mode
      assign pin_ev = (pin_d_r[gi] && !pin_now)
        || (expand_r[gi] && cause_r[gi] == TCDMA_CAUSE_PIN2E
            && !pin_d_r[gi] && pin_now);
      always_comb
      begin
        cause_ev = 1'b0;
        if (cause_r[gi] == TCDMA_CAUSE_PIN)
          cause_ev = pin_ev;
        else if (cause_r[gi] == TCDMA_CAUSE_PIN2E && expand_r[gi])
          cause_ev = pin_ev;
        else if (cause_r[gi] == TCDMA_CAUSE_SW)
          cause_ev = 1'b0;
        else
          cause_ev = periph_req_i[{expand_r[gi], cause_r[gi][2:0]}];
      end
      assign req_ev[gi] = cause_ev || sw_req[gi];
      assign start_en[gi] = wr_ctrl[gi] && pwdata_i[TCDMA_B_EN]
        && !ctrl_r[gi].enable;
      assign underflow[gi] = state_r == ST_UPD && ch_r == gi[0]
        && count_r[gi] == 16'h0000;

      always_ff @(posedge sys_clk_i)
      begin
        if (!rst_n_i)
          pin_d_r[gi] <= 1'b1;
        else
          pin_d_r[gi] <= pin_now;
      end

      always_ff @(posedge sys_clk_i)
      begin
        if (!rst_n_i)
        begin
          ctrl_r[gi] <= '0;
          cause_r[gi] <= 4'h0;
          expand_r[gi] <= 1'b0;
        end
        else
        begin
          if (wr_ctrl[gi])
          begin
            ctrl_r[gi].byte_unit <= pwdata_i[TCDMA_B_UNIT];
            ctrl_r[gi].repeat_mode <= pwdata_i[TCDMA_B_REPEAT];
            ctrl_r[gi].enable <= pwdata_i[TCDMA_B_EN];
            // forward on both sides is refused
            if (!(pwdata_i[TCDMA_B_SRCDIR] && pwdata_i[TCDMA_B_DSTDIR]))
            begin
              ctrl_r[gi].src_dir <= pwdata_i[TCDMA_B_SRCDIR];
              ctrl_r[gi].dst_dir <= pwdata_i[TCDMA_B_DSTDIR];
            end
          end
          if (wr_cause[gi])
          begin
            cause_r[gi] <= pwdata_i[3:0];
            expand_r[gi] <= pwdata_i[TCDMA_B_EXPAND];
          end
          // set wins over software clear
          if (req_ev[gi] && (ctrl_r[gi].enable || start_en[gi]))
            ctrl_r[gi].pend <= 1'b1;
          else if (wr_ctrl[gi] && !pwdata_i[TCDMA_B_PEND])
            ctrl_r[gi].pend <= 1'b0;
          else if (state_r == ST_RD && ch_r == gi[0] && mem_ack_i)
            ctrl_r[gi].pend <= 1'b0;
          if (underflow[gi] && !ctrl_r[gi].repeat_mode)
            ctrl_r[gi].enable <= 1'b0;
        end
      end

      always_ff @(posedge sys_clk_i)
      begin
        if (!rst_n_i)
        begin
          src_r[gi] <= '0;
          dst_r[gi] <= '0;
          reload_r[gi] <= TCDMA_CNT_RST;
        end
        else
        begin
          if (wr_src[gi])
            src_r[gi] <= pwdata_i[19:0];
          if (wr_dst[gi])
            dst_r[gi] <= pwdata_i[19:0];
          if (wr_reload[gi])
            reload_r[gi] <= pwdata_i[15:0];
        end
      end

      always_ff @(posedge sys_clk_i)
      begin
        if (!rst_n_i)
        begin
          fwd_r[gi] <= '0;
          count_r[gi] <= TCDMA_CNT_RST;
        end
        else if (start_en[gi])
        begin
          fwd_r[gi] <= pwdata_i[TCDMA_B_DSTDIR] ? dst_r[gi]
                       : src_r[gi];
          count_r[gi] <= reload_r[gi];
        end
        else if (state_r == ST_UPD && ch_r == gi[0])
        begin
          if (count_r[gi] == 16'h0000)
            count_r[gi] <= reload_r[gi];
          else
            count_r[gi] <= count_r[gi] - 16'h0001;
        end
        if (rst_n_i && (state_r == ST_UPD || state_r == ST_SKIP)
            && ch_r == gi[0] && !start_en[gi]
            && (ctrl_r[gi].src_dir || ctrl_r[gi].dst_dir))
          fwd_r[gi] <= fwd_r[gi] + (ctrl_r[gi].byte_unit ? 20'h0_0001
                       : 20'h0_0002);
      end
    end
  endgenerate

  // ==========================================================
  // register read mux
  // ==========================================================
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (ofs)
      TCDMA_OFS_CTRL: rd_mux = {26'h0, ctrl_r[ch_sel]};
      TCDMA_OFS_CAUSE: rd_mux = {26'h0, expand_r[ch_sel], 1'b0,
                                 cause_r[ch_sel]};
      TCDMA_OFS_SRC: rd_mux = {12'h0, (ctrl_r[ch_sel].enable
        && ctrl_r[ch_sel].src_dir) ? fwd_r[ch_sel] : src_r[ch_sel]};
      TCDMA_OFS_DST: rd_mux = {12'h0, (ctrl_r[ch_sel].enable
        && ctrl_r[ch_sel].dst_dir) ? fwd_r[ch_sel] : dst_r[ch_sel]};
      TCDMA_OFS_RELOAD: rd_mux = {16'h0, reload_r[ch_sel]};
      TCDMA_OFS_COUNT: rd_mux = {16'h0, count_r[ch_sel]};
      TCDMA_OFS_STATUS: rd_mux = {29'h0, state_r != ST_IDLE, ch_r,
                                  bus_own_o};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // transfer engine
  // ==========================================================
  assign rd_addr = ctrl_r[ch_r].src_dir ? fwd_r[ch_r] : src_r[ch_r];
  assign wr_addr = ctrl_r[ch_r].dst_dir ? fwd_r[ch_r] : dst_r[ch_r];

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= ST_IDLE;
      ch_r <= 1'b0;
      data_r <= 16'h0000;
      mem_req_o <= '0;
      bus_own_o <= 1'b0;
      dma_irq_o <= 2'b00;
    end
    else
    begin
      dma_irq_o <= underflow;
      unique case (state_r)
        ST_IDLE:
        begin
          mem_req_o <= '0;
          bus_own_o <= 1'b0;
          if (ctrl_r[0].enable && ctrl_r[0].pend)
            ch_r <= 1'b0;
          else
            ch_r <= 1'b1;
          if ((ctrl_r[0].enable && ctrl_r[0].pend)
              || (ctrl_r[1].enable && ctrl_r[1].pend))
          begin
            state_r <= ST_RD;
            bus_own_o <= 1'b1;
          end
        end
        ST_RD:
        begin
          // protected window: unit dropped, bus untouched
          if ((rd_addr >= TCDMA_PROT_LO && rd_addr <= TCDMA_PROT_HI)
              || (wr_addr >= TCDMA_PROT_LO && wr_addr <= TCDMA_PROT_HI))
            state_r <= ST_SKIP;
          else if (mem_ack_i && mem_req_o.req)
          begin
            data_r <= mem_rdata_i;
            mem_req_o <= '{addr: wr_addr, wdata: mem_rdata_i, we: 1'b1,
                           word: !ctrl_r[ch_r].byte_unit, req: 1'b1};
            state_r <= ST_WR;
          end
          else
            mem_req_o <= '{addr: rd_addr, wdata: data_r, we: 1'b0,
                           word: !ctrl_r[ch_r].byte_unit, req: 1'b1};
        end
        ST_WR:
        begin
          if (mem_ack_i)
          begin
            mem_req_o <= '0;
            state_r <= ST_UPD;
          end
        end
        ST_UPD:
        begin
          bus_own_o <= 1'b0;
          state_r <= ST_IDLE;
        end
        ST_SKIP:
        begin
          mem_req_o <= '0;
          bus_own_o <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : tcdma_top

// ===== shared/tcdma_pkg.sv
// tcdma_pkg: register map, field positions and carrier types of the
// two-channel cycle-steal dma controller.
// assumes a 32-bit apb register port and a 20-bit system bus.
package tcdma_pkg;

  // ==========================================================
  // register map (byte addresses, one word per register)
  // ==========================================================
  localparam logic [7:0] TCDMA_CH_STRIDE = 8'h20;
  localparam logic [7:0] TCDMA_OFS_CTRL = 8'h00;
  localparam logic [7:0] TCDMA_OFS_CAUSE = 8'h04;
  localparam logic [7:0] TCDMA_OFS_SRC = 8'h08;
  localparam logic [7:0] TCDMA_OFS_DST = 8'h0C;
  localparam logic [7:0] TCDMA_OFS_RELOAD = 8'h10;
  localparam logic [7:0] TCDMA_OFS_COUNT = 8'h14;
  localparam logic [7:0] TCDMA_OFS_STATUS = 8'h18;

  // ==========================================================
  // control register fields
  // ==========================================================
  localparam int TCDMA_B_UNIT = 0;
  localparam int TCDMA_B_REPEAT = 1;
  localparam int TCDMA_B_PEND = 2;
  localparam int TCDMA_B_EN = 3;
  localparam int TCDMA_B_SRCDIR = 4;
  localparam int TCDMA_B_DSTDIR = 5;

  // cause register fields
  localparam int TCDMA_B_EXPAND = 5;
  localparam int TCDMA_B_SWREQ = 7;

  // ==========================================================
  // request causes (4-bit select)
  // ==========================================================
  localparam logic [3:0] TCDMA_CAUSE_PIN = 4'h0;
  localparam logic [3:0] TCDMA_CAUSE_SW = 4'h1;
  localparam logic [3:0] TCDMA_CAUSE_PIN2E = 4'h7;

  // ==========================================================
  // address space and protected window
  // ==========================================================
  localparam int TCDMA_AW = 20;
  localparam logic [19:0] TCDMA_PROT_LO = 20'h0_0020;
  localparam logic [19:0] TCDMA_PROT_HI = 20'h0_003F;
  localparam logic [15:0] TCDMA_CNT_RST = 16'h0000;

  // ==========================================================
  // carrier types
  // ==========================================================
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] wdata;
    logic we;
    logic word;
    logic req;
  } tcdma_bus_req_t;

  typedef struct packed {
    logic dst_dir;
    logic src_dir;
    logic enable;
    logic pend;
    logic repeat_mode;
    logic byte_unit;
  } tcdma_ctrl_t;

endpackage : tcdma_pkg

// ===== verif/tcdma_top_sva.sv
// tcdma_top_sva: port-level checks of the dma controller.
// assumes one clock domain and binding onto tcdma_top.
`timescale 1ns/100ps
module tcdma_top_sva
  import tcdma_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire tcdma_bus_req_t mem_req_o,
  input wire logic bus_own_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  input wire logic [1:0] dma_irq_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ==========
  // bus sequences
  sequence s_wait;
    mem_req_o.req && !mem_ack_i;
  endsequence
  sequence s_rd_done;
    mem_req_o.req && !mem_req_o.we && mem_req_o.word && mem_ack_i;
  endsequence
  // ==========
  // assertions
  a_apb_answer: assert property (
    psel_i && !penable_i |=> pready_o) else $error("ready missing");
  a_ready_single: assert property (
    pready_o |=> !pready_o) else $error("ready too long");
  a_err_ready: assert property (
    pslverr_o |-> pready_o) else $error("error without ready");
  a_req_held: assert property (
    s_wait |=> mem_req_o.req && $stable(mem_req_o.addr))
    else $error("request dropped early");
  a_prot_window: assert property (
    mem_req_o.req |-> mem_req_o.addr < TCDMA_PROT_LO
    || mem_req_o.addr > TCDMA_PROT_HI) else $error("window accessed");
  a_own_bus: assert property (
    mem_req_o.req |-> bus_own_o) else $error("request without bus");
  a_write_data: assert property (
    s_rd_done |=> mem_req_o.req && mem_req_o.we
    && mem_req_o.wdata == $past(mem_rdata_i)) else $error("bad write");
  a_irq_pulse: assert property (
    |dma_irq_o |=> dma_irq_o == 2'b00) else $error("irq too long");
  a_irq_owned: assert property (
    |dma_irq_o |-> $past(bus_own_o)) else $error("irq without transfer");
endmodule : tcdma_top_sva

bind tcdma_top tcdma_top_sva i_tcdma_top_sva (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .mem_req_o(mem_req_o), .bus_own_o(bus_own_o), .mem_ack_i(mem_ack_i),
  .mem_rdata_i(mem_rdata_i), .dma_irq_o(dma_irq_o));

// ===== verif/tcdma_mem_model.sv
// tcdma_mem_model: system memory answering the dma bus port.
// assumes one request at a time; ack lasts one cycle.
`timescale 1ns/100ps
module tcdma_mem_model
  import tcdma_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic slow_i,
  input wire tcdma_bus_req_t req_i,
  output logic ack_o,
  output logic [15:0] rdata_o
);
  // ==========
  // answer logic
  int n_wr = 0;
  logic [2:0] wait_r = 3'h0;
  logic [31:0] wa[$];
  logic [31:0] wd[$];
  initial
  begin
    ack_o = 1'b0;
    rdata_o = 16'h0000;
  end
  always @(posedge sys_clk_i)
  begin
    ack_o <= 1'b0;
    // data toggles while not answering
    rdata_o <= ~rdata_o;
    if (req_i.req && !ack_o)
    begin
      wait_r <= wait_r + 3'h1;
      if (wait_r >= (slow_i ? 3'h3 : 3'h0))
      begin
        wait_r <= 3'h0;
        ack_o <= 1'b1;
        rdata_o <= req_i.addr[15:0] ^ 16'h5a5a;
        if (req_i.we)
        begin
          n_wr <= n_wr + 1;
          wa.push_back({12'h000, req_i.addr});
          wd.push_back({16'h0000, req_i.wdata});
        end
      end
    end
  end
endmodule : tcdma_mem_model

// ===== verif/tcdma_top_test.sv
// tcdma_top_test: register-level tests of the dma controller.
// assumes tcdma_mem_model on the bus port and the bound checker.
`timescale 1ns/100ps
module tcdma_top_test;
  import tcdma_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pin0 = 1'b1, pin1 = 1'b1, slow = 1'b0;
  logic pready, se, ack, own, qerr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic [15:0] preq = 16'h0000, rdata;
  logic [1:0] irq;
  tcdma_bus_req_t mreq;
  int n_fail = 0, tests_run = 0, cyc = 0, i0 = 0, i1 = 0;
  // ==========
  // design and partner
  tcdma_top i_tcdma_top (.sys_clk_i(clk), .rst_n_i(rst_n),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(se), .ext_irq_pin_zero_i(pin0),
    .ext_irq_pin_one_i(pin1), .periph_req_i(preq), .mem_req_o(mreq),
    .bus_own_o(own), .mem_ack_i(ack), .mem_rdata_i(rdata),
    .dma_irq_o(irq));
  tcdma_mem_model i_tcdma_mem_model (.sys_clk_i(clk), .slow_i(slow),
    .req_i(mreq), .ack_o(ack), .rdata_o(rdata));
  initial
  begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    i0 += int'(irq[0] === 1'b1);
    i1 += int'(irq[1] === 1'b1);
    if (cyc == 20000)
    begin
      n_fail++;
      conclude();
    end
  end
  // ==========
  // tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    qerr = se;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask : rd
  task automatic wt(input int n);
    while (i_tcdma_mem_model.n_wr < n)
    begin
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : wt
  // ==========
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    rd(8'h1C, 32'h0000_0000);
    chk({31'h0, qerr}, 32'h0000_0001);
    wr(8'h04, 32'h0000_0001);
    wr(8'h08, 32'h0000_0100);
    wr(8'h0C, 32'h0000_0200);
    wr(8'h10, 32'h0000_0001);
    wr(8'h00, 32'h0000_0028);
    wr(8'h08, 32'h0000_0300);
    rd(8'h08, 32'h0000_0100);
    wr(8'h00, 32'h0000_0038);
    rd(8'h00, 32'h0000_0028);
    wr(8'h04, 32'h0000_0081);
    rd(8'h04, 32'h0000_0001);
    wt(1);
    chk(i_tcdma_mem_model.wa[0], 32'h0000_0200);
    chk(i_tcdma_mem_model.wd[0], 32'h0000_5b5a);
    rd(8'h0C, 32'h0000_0202);
    rd(8'h14, 32'h0000_0000);
    slow <= 1'b1;
    wr(8'h04, 32'h0000_0081);
    wt(2);
    chk(i_tcdma_mem_model.wa[1], 32'h0000_0202);
    rd(8'h00, 32'h0000_0020);
    chk(i0, 32'h0000_0001);
    wr(8'h04, 32'h0000_0081);
    repeat (40) @(posedge clk);
    chk(i_tcdma_mem_model.n_wr, 32'h0000_0002);
    wr(8'h04, 32'h0000_0000);
    wr(8'h08, 32'h0000_0400);
    wr(8'h0C, 32'h0000_0500);
    wr(8'h10, 32'h0000_0000);
    wr(8'h00, 32'h0000_0008);
    wr(8'h24, 32'h0000_0000);
    wr(8'h28, 32'h0000_0600);
    wr(8'h2C, 32'h0000_0700);
    wr(8'h30, 32'h0000_0000);
    wr(8'h20, 32'h0000_001B);
    @(posedge clk);
    pin0 <= 1'b0;
    pin1 <= 1'b0;
    wt(4);
    chk(i_tcdma_mem_model.wa[2], 32'h0000_0500);
    chk(i_tcdma_mem_model.wa[3], 32'h0000_0700);
    rd(8'h20, 32'h0000_001B);
    rd(8'h34, 32'h0000_0000);
    rd(8'h28, 32'h0000_0601);
    chk(i1, 32'h0000_0001);
    chk(i0, 32'h0000_0002);
    wr(8'h24, 32'h0000_0027);
    pin1 <= 1'b1;
    wt(5);
    chk(i_tcdma_mem_model.n_wr, 32'h0000_0005);
    wr(8'h24, 32'h0000_0002);
    preq <= 16'h0004;
    @(posedge clk);
    preq <= 16'h0000;
    wt(6);
    chk(i_tcdma_mem_model.n_wr, 32'h0000_0006);
    rd(8'h28, 32'h0000_0603);
    // source inside the register window: units skipped, pend stays
    wr(8'h08, 32'h0000_0020);
    wr(8'h04, 32'h0000_0001);
    wr(8'h00, 32'h0000_0028);
    wr(8'h04, 32'h0000_0081);
    rd(8'h00, 32'h0000_002C);
    wr(8'h00, 32'h0000_0020);
    rd(8'h00, 32'h0000_0020);
    chk(i_tcdma_mem_model.n_wr, 32'h0000_0006);
    conclude();
  end
endmodule : tcdma_top_test
